// ---- crp_pkg.sv ----
// Package: constants for the codec reset and power control block, shared by both ends
package crp_pkg;
  localparam logic [6:0]  CRP_I2C_ADDR      = 7'h18;
  localparam logic [7:0]  CRP_PAGE_SEL_OFS  = 8'h00;
  localparam logic [7:0]  CRP_SW_RESET_OFS  = 8'h01;
  localparam logic [7:0]  CRP_HP_RESET_OFS  = 8'h1f;
  localparam logic [7:0]  CRP_SPK_RESET_OFS = 8'h20;
  localparam logic [7:0]  CRP_TOUCH_PWR_OFS = 8'h04;
  localparam logic [7:0]  CRP_PWR_CTRL_OFS  = 8'h02;
  localparam logic [7:0]  CRP_STATUS_OFS    = 8'h03;
  localparam logic [7:0]  CRP_SAR_DATA_OFS  = 8'h05;
  localparam logic [7:0]  CRP_PAGE0         = 8'h00;
  localparam logic [7:0]  CRP_PAGE1         = 8'h01;
  localparam logic [7:0]  CRP_PAGE3         = 8'h03;
  localparam int          CRP_SW_RESET_BIT  = 0;
  localparam int          CRP_LEFT_BIT      = 7;
  localparam int          CRP_RIGHT_BIT     = 6;
  localparam int          CRP_TOUCH_PD_BIT  = 7;
  localparam int          CRP_PLL_PWR_BIT   = 7;
  localparam int          CRP_ST_INIT_BIT   = 0;
  localparam int          CRP_ST_CLK_BIT    = 1;
  localparam logic [7:0]  CRP_REG_RST       = 8'h00;
  localparam int          CRP_CLK_MHZ       = 100;
  localparam int          CRP_INIT_US       = 1000;
  localparam int          CRP_PLL_US        = 10000;
  localparam int          CRP_INIT_CYC      = CRP_INIT_US * CRP_CLK_MHZ;
  localparam int          CRP_PLL_CYC       = CRP_PLL_US * CRP_CLK_MHZ;
  localparam int          CRP_RESET_NS      = 10;
  localparam int          CRP_RESET_CYC     = (CRP_RESET_NS * CRP_CLK_MHZ + 999) / 1000;
endpackage : crp_pkg

// ---- crp_link_if.sv ----
// Interface: I2C target link between host controller and device
`timescale 1ns/1ps
`default_nettype none
interface crp_link_if;
  logic scl;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic hw_reset_n;
  wire  sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));
  modport dev  (input scl, input sda, input hw_reset_n, output sda_dev_o, output sda_dev_oe);
  modport host (output scl, input sda, output hw_reset_n, output sda_host_o, output sda_host_oe);
endinterface : crp_link_if
`default_nettype wire

// ---- crp_device.sv ----
// Device end: I2C target register file with reset, init-busy flag and power-stage control
`timescale 1ns/1ps
`default_nettype none
module crp_device
  import crp_pkg::*;
#(
  parameter int INIT_CYC = crp_pkg::CRP_INIT_CYC,
  parameter int PLL_CYC  = crp_pkg::CRP_PLL_CYC
) (
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  crp_link_if.dev    link,
  input  wire logic  [1:0] overcurrent_i,
  input  wire logic  [1:0] spk_overcurrent_i,
  input  wire logic  [7:0] sar_data_i,
  output logic       [1:0] hp_enabled_o,
  output logic       [1:0] spk_enabled_o,
  output logic       pll_power_o,
  output logic       clocks_ready_o,
  output logic       touch_active_o,
  output logic       init_busy_o
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_DATA, S_DACK, S_RD, S_RACK} crp_i2c_st_t;
  crp_i2c_st_t st_r;
  logic [1:0] scl_s, sda_s;
  logic [7:0] sh_r, ptr_r, page_r, pwr_r, touch_r;
  logic [3:0] cnt_r;
  logic       rw_r, ptr_set_r, sda_drv_r, sdo_r;
  logic [1:0] hp_lat_r, spk_lat_r;
  logic [31:0] init_cnt_r, pll_cnt_r;
  logic       soft_rst_r, soft_pend_r;
  logic [7:0] rd_data;
  logic       scl_rise, scl_fall, start_c, stop_c, wr_byte;
  // Reset both on the pin and on the self-clearing software reset
  wire  any_rst_n = rst_n_i & link.hw_reset_n;
  wire  soft_rst_n = any_rst_n & ~soft_rst_r;
  assign scl_rise = scl_s == 2'b01;
  assign scl_fall = scl_s == 2'b10;
  assign start_c  = scl_s[1] & scl_s[0] & sda_s == 2'b10;
  assign stop_c   = scl_s[1] & scl_s[0] & sda_s == 2'b01;
  assign wr_byte  = st_r == S_DATA && scl_rise && cnt_r == 4'd7 && ptr_set_r;
  wire  [7:0] wr_val = {sh_r[6:0], sda_s[1]};
  wire  sel0 = page_r == CRP_PAGE0;
  wire  sel1 = page_r == CRP_PAGE1;
  wire  sel3 = page_r == CRP_PAGE3;
  wire  wr_sw  = wr_byte & sel0 & ptr_r == CRP_SW_RESET_OFS & wr_val[CRP_SW_RESET_BIT];
  wire  wr_hp  = wr_byte & sel1 & ptr_r == CRP_HP_RESET_OFS;
  wire  wr_spk = wr_byte & sel1 & ptr_r == CRP_SPK_RESET_OFS;
  // Status carries the lockout and clock-ready flags; SAR data goes to the control bus
  assign rd_data = (ptr_r == CRP_PAGE_SEL_OFS) ? page_r :
                   (sel0 && ptr_r == CRP_PWR_CTRL_OFS) ? pwr_r :
                   (sel0 && ptr_r == CRP_STATUS_OFS) ? {6'h00, clocks_ready_o, init_busy_o} :
                   (sel0 && ptr_r == CRP_SAR_DATA_OFS) ? sar_data_i :
                   (sel1 && ptr_r == CRP_HP_RESET_OFS) ? {hp_lat_r, 6'h00} :
                   (sel1 && ptr_r == CRP_SPK_RESET_OFS) ? {spk_lat_r, 6'h00} :
                   (sel3 && ptr_r == CRP_TOUCH_PWR_OFS) ? touch_r : 8'h00;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
    end else begin
      scl_s <= {scl_s[0], link.scl};
      sda_s <= {sda_s[0], link.sda};
    end
  end

  // Held until stop so the writing frame still gets its ack
  always_ff @(posedge clk_i or negedge any_rst_n) begin
    if (!any_rst_n) begin
      soft_pend_r <= 1'b0;
      soft_rst_r  <= 1'b0;
    end else begin
      soft_pend_r <= (soft_pend_r & ~stop_c) | wr_sw;
      soft_rst_r  <= soft_pend_r & stop_c;
    end
  end

  // Target-only state machine; never drives clock or starts a transfer
  always_ff @(posedge clk_i or negedge soft_rst_n) begin
    if (!soft_rst_n) begin
      st_r <= S_IDLE; sh_r <= 8'h00; cnt_r <= 4'h0; rw_r <= 1'b0;
      ptr_r <= 8'h00; ptr_set_r <= 1'b0; sda_drv_r <= 1'b0; sdo_r <= 1'b1;
      page_r <= CRP_REG_RST; pwr_r <= CRP_REG_RST; touch_r <= CRP_REG_RST;
    end else if (start_c) begin
      st_r <= S_ADDR; cnt_r <= 4'h0; sda_drv_r <= 1'b0; ptr_set_r <= 1'b0;
    end else if (stop_c) begin
      st_r <= S_IDLE; sda_drv_r <= 1'b0;
    end else begin
      unique case (st_r)
        S_IDLE: ;
        S_ADDR: if (scl_rise) begin
          sh_r <= wr_val; cnt_r <= cnt_r + 4'd1;
          if (cnt_r == 4'd7) begin
            rw_r <= sda_s[1];
            st_r <= (sh_r[6:0] == CRP_I2C_ADDR) ? S_ACK : S_IDLE;
          end
        end
        S_ACK: if (scl_fall) begin
          if (!sda_drv_r) begin
            sda_drv_r <= 1'b1; sdo_r <= 1'b0;
          end else if (rw_r) begin
            st_r <= S_RD; cnt_r <= 4'h0; sh_r <= rd_data; sdo_r <= rd_data[7];
          end else begin
            sda_drv_r <= 1'b0; st_r <= S_DATA; cnt_r <= 4'h0;
          end
        end
        S_DATA: if (scl_rise) begin
          sh_r <= wr_val; cnt_r <= cnt_r + 4'd1;
          if (cnt_r == 4'd7) begin
            st_r <= S_DACK;
            if (!ptr_set_r) begin
              ptr_r <= wr_val; ptr_set_r <= 1'b1;
            end else begin
              if (ptr_r == CRP_PAGE_SEL_OFS) page_r <= wr_val;
              else if (sel0 && ptr_r == CRP_PWR_CTRL_OFS) pwr_r <= wr_val;
              else if (sel3 && ptr_r == CRP_TOUCH_PWR_OFS) touch_r <= wr_val;
              ptr_r <= ptr_r + 8'd1;
            end
          end
        end
        S_DACK: if (scl_fall) begin
          if (!sda_drv_r) begin
            sda_drv_r <= 1'b1; sdo_r <= 1'b0;
          end else begin
            sda_drv_r <= 1'b0; st_r <= S_DATA; cnt_r <= 4'h0;
          end
        end
        S_RD: if (scl_fall) begin
          cnt_r <= cnt_r + 4'd1; sh_r <= {sh_r[6:0], 1'b0};
          if (cnt_r == 4'd7) begin
            sda_drv_r <= 1'b0; st_r <= S_RACK; ptr_r <= ptr_r + 8'd1;
          end else begin
            sdo_r <= sh_r[6];
          end
        end
        S_RACK: if (scl_rise) begin
          // Host NACK ends the read; ACK fetches the next register
          if (sda_s[1]) st_r <= S_IDLE;
          else          st_r <= S_ACK;
          // Armed but released: the line must not move while the clock is high
          sda_drv_r <= ~sda_s[1];
          sdo_r     <= 1'b1;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Overcurrent latches a stage off; its own reset bit, the software reset or the reset pin restores it
  always_ff @(posedge clk_i or negedge soft_rst_n) begin
    if (!soft_rst_n) begin
      hp_lat_r  <= 2'b00;
      spk_lat_r <= 2'b00;
    end else begin
      hp_lat_r  <= (hp_lat_r & ~(wr_hp ? wr_val[CRP_LEFT_BIT -: 2] : 2'b00)) | overcurrent_i;
      spk_lat_r <= (spk_lat_r & ~(wr_spk ? wr_val[CRP_LEFT_BIT -: 2] : 2'b00)) | spk_overcurrent_i;
    end
  end

  always_ff @(posedge clk_i or negedge soft_rst_n) begin
    if (!soft_rst_n) begin
      init_cnt_r <= 32'h0000_0000;
      pll_cnt_r  <= 32'h0000_0000;
    end else begin
      if (init_cnt_r < 32'(INIT_CYC)) init_cnt_r <= init_cnt_r + 32'd1;
      if (!pwr_r[CRP_PLL_PWR_BIT]) pll_cnt_r <= 32'h0000_0000;
      else if (pll_cnt_r < 32'(PLL_CYC)) pll_cnt_r <= pll_cnt_r + 32'd1;
    end
  end

  assign init_busy_o    = init_cnt_r < 32'(INIT_CYC);
  assign clocks_ready_o = pll_cnt_r == 32'(PLL_CYC);
  assign pll_power_o    = pwr_r[CRP_PLL_PWR_BIT];
  assign touch_active_o = ~touch_r[CRP_TOUCH_PD_BIT];
  assign hp_enabled_o   = ~hp_lat_r;
  assign spk_enabled_o  = ~spk_lat_r;
  assign link.sda_dev_o  = sdo_r;
  assign link.sda_dev_oe = sda_drv_r & ~sdo_r;
endmodule : crp_device
`default_nettype wire

// ---- crp_host.sv ----
// Host end: I2C controller issuing single register accesses and driving hardware reset
`timescale 1ns/1ps
`default_nettype none
module crp_host
  import crp_pkg::*;
#(
  parameter int HALF_CYC = 8
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  crp_link_if.host        link,
  input  wire logic       reset_req_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic            busy_o,
  output logic            done_o,
  output logic            nack_o
);
  typedef enum logic [1:0] {H_IDLE, H_RST, H_XFER} crp_host_st_t;
  crp_host_st_t st_r;
  logic [35:0] seq_r;
  logic [5:0]  bit_r;
  logic [1:0]  ph_r;
  logic [7:0]  div_r, rx_r;
  logic        rw_r, scl_r, sda_r, rst_r, rs_r;
  wire  tick = div_r == 8'(HALF_CYC - 1);
  // Extra slot before the read address makes the repeated start
  wire  restart = rw_r && bit_r == 6'd18 && !rs_r;
  // Frame: address+W, register, then data byte or (repeated start) address+R
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= H_IDLE; seq_r <= '0; bit_r <= '0; ph_r <= '0; div_r <= '0;
      rx_r <= '0; rw_r <= 1'b0; scl_r <= 1'b1; sda_r <= 1'b1; rst_r <= 1'b0; rs_r <= 1'b0;
      rdata_o <= '0; done_o <= 1'b0; nack_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      div_r  <= tick ? 8'h00 : div_r + 8'd1;
      unique case (st_r)
        H_IDLE: begin
          rst_r <= 1'b1;
          if (reset_req_i) begin
            st_r <= H_RST; rst_r <= 1'b0; bit_r <= 6'(CRP_RESET_CYC);
          end else if (wr_i | rd_i) begin
            st_r <= H_XFER; rw_r <= rd_i; bit_r <= 6'd0; ph_r <= 2'd0; div_r <= 8'h00;
            seq_r <= {CRP_I2C_ADDR, 1'b0, 1'b1, addr_i, 1'b1, rd_i ? {CRP_I2C_ADDR, 1'b1} : wdata_i,
                      1'b1, 8'hff, 1'b1};
            sda_r <= 1'b0; nack_o <= 1'b0; rs_r <= 1'b0;
          end
        end
        H_RST: begin
          bit_r <= bit_r - 6'd1;
          if (bit_r == 6'd0) begin
            st_r <= H_IDLE; rst_r <= 1'b1; done_o <= 1'b1;
          end
        end
        H_XFER: if (tick) begin
          ph_r <= ph_r + 2'd1;
          unique case (ph_r)
            2'd0: scl_r <= 1'b0;
            2'd1: sda_r <= restart ? 1'b1 : (bit_r == 6'd36 || (bit_r == 6'd27 && !rw_r)) ? 1'b0 : seq_r[35];
            2'd2: begin
              scl_r <= 1'b1;
              if (bit_r == 6'd8 || bit_r == 6'd17 || bit_r == 6'd26) nack_o <= nack_o | link.sda;
              if (rw_r && bit_r >= 6'd27 && bit_r < 6'd35) rx_r <= {rx_r[6:0], link.sda};
            end
            2'd3: begin
              if (restart) begin
                sda_r <= 1'b0; rs_r <= 1'b1;
              end else begin
                seq_r <= {seq_r[34:0], 1'b1};
                bit_r <= bit_r + 6'd1;
              end
              if (bit_r == 6'd36 || (bit_r == 6'd27 && !rw_r)) begin
                sda_r <= 1'b1; st_r <= H_IDLE; done_o <= 1'b1; rdata_o <= rx_r;
              end
            end
            default: ;
          endcase
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end
  assign busy_o           = st_r != H_IDLE;
  assign link.scl         = scl_r;
  assign link.sda_host_o  = sda_r;
  assign link.sda_host_oe = ~sda_r;
  assign link.hw_reset_n  = rst_r;
endmodule : crp_host
`default_nettype wire

// ---- crp_sva.sv ----
// Checker: wire-level properties of the host-device control link
`timescale 1ns/1ps
`default_nettype none
module crp_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic hw_reset_n
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Target may only move its pull-down while the clock is low
  a_dev_oe_moves: assert property ($changed(sda_dev_oe) && hw_reset_n && $past(hw_reset_n) |-> !scl)
    else $error("device data enable moved with clock high");
  a_start_by_host: assert property (scl && $past(scl) && $fell(sda) |-> sda_host_oe && !sda_dev_oe)
    else $error("start not made by host");
  a_stop_released: assert property (scl && $past(scl) && $rose(sda) |-> !sda_dev_oe)
    else $error("device holds data line at stop");
  a_dev_reset_quiet: assert property (!hw_reset_n |-> !sda_dev_oe)
    else $error("device drives data during reset");
  a_reset_pulse_len: assert property ($fell(hw_reset_n) |-> ##[1:8] hw_reset_n)
    else $error("reset pulse not released in time");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*2])
    else $error("clock high phase too short");
  a_scl_low_bound: assert property ($fell(scl) |-> ##[1:64] scl)
    else $error("clock held low too long");
  a_dev_oe_bounded: assert property ($rose(sda_dev_oe) |-> ##[1:400] !sda_dev_oe)
    else $error("device pull-down never released");
  c_dev_ack: cover property ($rose(sda_dev_oe));
  c_hw_reset: cover property ($fell(hw_reset_n));
  c_frame_start: cover property (scl && $fell(sda));
endmodule // crp_sva
`default_nettype wire

// ---- test_codec_reset_power_control.sv ----
// Testbench: host and device ends joined over the control link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; $display("[ERR] %0t %0h %0h", $time, (a), (e)); end end
module test_codec_reset_power_control;
  import crp_pkg::*;
  localparam int INIT_C = 50;
  localparam int PLL_C  = 100;
  logic        clk_i, rst_n_i, reset_req, wr, rd, busy, done, nack;
  logic        pll_pwr, clk_rdy, touch_act, init_busy;
  logic [7:0]  addr, wdata, rdata, sar, pwr_val, ofs;
  logic [1:0]  oc, spk_oc, hp_en, spk_en;
  logic [15:0] busy_cnt = '0, pll_cnt = '0;
  int          num_errors = 0;
  int          cmp_count = 0;
  crp_link_if i_crp_link_if ();
  crp_device #(.INIT_CYC(INIT_C), .PLL_CYC(PLL_C)) i_crp_device (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .link(i_crp_link_if), .overcurrent_i(oc), .spk_overcurrent_i(spk_oc), .sar_data_i(sar),
    .hp_enabled_o(hp_en), .spk_enabled_o(spk_en), .pll_power_o(pll_pwr), .clocks_ready_o(clk_rdy),
    .touch_active_o(touch_act), .init_busy_o(init_busy));
  crp_host #(.HALF_CYC(8)) i_crp_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(i_crp_link_if),
    .reset_req_i(reset_req), .wr_i(wr), .rd_i(rd), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
    .busy_o(busy), .done_o(done), .nack_o(nack));
  crp_sva i_crp_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl(i_crp_link_if.scl), .sda(i_crp_link_if.sda),
    .sda_host_oe(i_crp_link_if.sda_host_oe), .sda_dev_oe(i_crp_link_if.sda_dev_oe),
    .hw_reset_n(i_crp_link_if.hw_reset_n));
  function automatic logic [3:0] exp_en(input int s, input int b);
    return 4'hf ^ (4'h1 << (s == 1 ? b : b + 2));
  endfunction
  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wr <= w; rd <= !w; addr <= a; wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0; rd <= 1'b0;
    #1;
    `CHK(busy, 1'b1)
    while (done !== 1'b1 && n < 4000) begin
      @(posedge clk_i); #1; n++;
    end
    if (n >= 4000) begin num_errors++; finish_test(); end
    `CHK(nack, 1'b0)
  endtask
  task automatic chk_defaults();
    int n;
    n = 0;
    // No register traffic until the default load is over
    while (init_busy !== 1'b0 && n < 200) begin
      @(posedge clk_i); #1; n++;
    end
    if (n >= 200) begin num_errors++; finish_test(); end
    `CHK({pll_pwr, touch_act, hp_en, spk_en}, 6'h1f)
  endtask
  // Cycle counters judge the lockout and settling windows
  always @(posedge clk_i) begin
    busy_cnt <= init_busy ? busy_cnt + 16'h1 : 16'h0;
    pll_cnt <= pll_pwr ? pll_cnt + 16'h1 : 16'h0;
    if (init_busy) `CHK(busy_cnt < 16'(INIT_C + 4), 1'b1)
    if (pll_pwr && pll_cnt < 16'(PLL_C - 2)) `CHK(clk_rdy, 1'b0)
    if (pll_cnt == 16'(PLL_C + 3)) `CHK(clk_rdy, 1'b1)
  end
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    rst_n_i = 1'b0; reset_req = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
    oc = 2'h0; spk_oc = 2'h0; sar = 8'h00;
    void'($urandom(32'h2110_69ee));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i); #1;
    `CHK(init_busy, 1'b1)
    chk_defaults();
    for (int i = 0; i < 4; i++) begin
      pwr_val = 8'($urandom);
      if (i == 3) pwr_val[CRP_PLL_PWR_BIT] = 1'b1;
      @(posedge clk_i);
      sar <= 8'($urandom);
      xfer(1'b1, CRP_PWR_CTRL_OFS, pwr_val);
      `CHK(pll_pwr, pwr_val[CRP_PLL_PWR_BIT])
      xfer(1'b0, CRP_PWR_CTRL_OFS, 8'h00);
      `CHK(rdata, pwr_val)
      xfer(1'b0, CRP_SAR_DATA_OFS, 8'h00);
      `CHK(rdata, sar)
      xfer(1'b0, CRP_STATUS_OFS, 8'h00);
      `CHK(rdata[CRP_ST_CLK_BIT], pwr_val[CRP_PLL_PWR_BIT])
    end
    for (int s = 0; s < 2; s++) begin
      for (int b = 0; b < 2; b++) begin
        ofs = (s == 1) ? CRP_SPK_RESET_OFS : CRP_HP_RESET_OFS;
        xfer(1'b1, CRP_PAGE_SEL_OFS, CRP_PAGE1);
        @(posedge clk_i);
        if (s == 1) spk_oc[b] <= 1'b1;
        else oc[b] <= 1'b1;
        @(posedge clk_i);
        oc <= 2'h0; spk_oc <= 2'h0;
        repeat (3) @(posedge clk_i);
        #1;
        `CHK({hp_en, spk_en}, exp_en(s, b))
        xfer(1'b0, ofs, 8'h00);
        `CHK(rdata, 8'(8'h40 << b))
        xfer(1'b1, ofs, 8'(8'h40 << b));
        `CHK({hp_en, spk_en}, 4'hf)
        xfer(1'b1, CRP_PAGE_SEL_OFS, CRP_PAGE0);
        xfer(1'b0, CRP_PWR_CTRL_OFS, 8'h00);
        `CHK(rdata, pwr_val)
      end
    end
    xfer(1'b1, CRP_PAGE_SEL_OFS, CRP_PAGE3);
    xfer(1'b1, CRP_TOUCH_PWR_OFS, 8'h80);
    `CHK(touch_act, 1'b0)
    xfer(1'b0, CRP_TOUCH_PWR_OFS, 8'h00);
    `CHK(rdata, 8'h80)
    xfer(1'b1, CRP_PAGE_SEL_OFS, CRP_PAGE0);
    xfer(1'b1, CRP_SW_RESET_OFS, 8'h01);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(init_busy, 1'b1)
    chk_defaults();
    xfer(1'b0, CRP_SW_RESET_OFS, 8'h00);
    `CHK(rdata, CRP_REG_RST)
    xfer(1'b0, CRP_PWR_CTRL_OFS, 8'h00);
    `CHK(rdata, CRP_REG_RST)
    xfer(1'b1, CRP_PWR_CTRL_OFS, 8'h80);
    @(posedge clk_i);
    reset_req <= 1'b1;
    @(posedge clk_i);
    reset_req <= 1'b0;
    repeat (CRP_RESET_CYC + 4) @(posedge clk_i);
    #1;
    `CHK(init_busy, 1'b1)
    chk_defaults();
    finish_test();
  end
endmodule // test_codec_reset_power_control
`default_nettype wire
